// ==== verilog/aalo_core.v ====
// add and logic datapath with axi4-lite register access
// Notes on behaviour
// - add literal to acc, set c dc z
// - and literal with acc, zero flag only
// - add acc and file register, c dc z
// - and acc with file register, zero only
// - dest bit clear: result to acc
// - dest bit set: file forms put result to file, literal forms still to acc
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "aalo_regs.vh"
module aalo_core #(
    parameter FILE_DEPTH = 128,
    parameter AW = 8
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi write address
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi read address
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);
    // instruction classes
    // anything outside the four forms is ignored and is not counted
    localparam CL_NONE = 3'h0;
    localparam CL_ADDLIT = 3'h1;
    localparam CL_ANDLIT = 3'h2;
    localparam CL_ADDFILE = 3'h3;
    localparam CL_ANDFILE = 3'h4;

    // decode the six opcode bits into an instruction class
    // add literal matches two codes, since bit 8 is a don't-care there
    function [2:0] decode;
        input [5:0] op;
        begin
            if ((op & `AALO_OP_ADDLIT_MASK) == `AALO_OP_ADDLIT)
                decode = CL_ADDLIT;
            else if (op == `AALO_OP_ANDLIT)
                decode = CL_ANDLIT;
            else if (op == `AALO_OP_ADDFILE)
                decode = CL_ADDFILE;
            else if (op == `AALO_OP_ANDFILE)
                decode = CL_ANDFILE;
            else
                decode = CL_NONE;
        end
    endfunction

    // architectural state
    reg [7:0] acc_ff; // working register
    reg [2:0] status_ff; // carry, digit carry, zero
    reg [7:0] file_ff [0:FILE_DEPTH-1]; // file registers
    reg [6:0] faddr_ff; // software window into file
    reg [15:0] count_ff; // executed instruction count
    // axi handshake state
    reg awready_ff; // write address slot free
    reg wready_ff; // write data slot free
    reg bvalid_ff; // write answer pending
    reg arready_ff; // read address slot free
    reg rvalid_ff; // read answer pending
    reg [1:0] bresp_ff; // write answer code
    reg [1:0] rresp_ff; // read answer code
    reg [31:0] rdata_ff; // read answer word
    reg [AW-1:0] awaddr_ff; // address parked until data comes
    reg [31:0] wdata_ff; // data parked until address comes
    reg wstrb0_ff; // lane 0 strobe parked with the data
    reg have_aw_ff; // address half already taken
    reg have_w_ff; // data half already taken

    // write channel bookkeeping
    // the two halves may come in either order; the first one is parked
    // in a holding register and the write runs once both are in
    wire aw_fire = s_axi_awvalid & awready_ff; // address taken this edge
    wire w_fire = s_axi_wvalid & wready_ff; // data taken this edge
    wire aw_now = have_aw_ff | aw_fire; // address available
    wire w_now = have_w_ff | w_fire; // data available
    wire [AW-1:0] wa = have_aw_ff ? awaddr_ff : s_axi_awaddr; // effective address
    wire [31:0] wd = have_w_ff ? wdata_ff : s_axi_wdata; // effective data
    // strobe must come from the data beat, not from the idle live bus
    wire lane0 = have_w_ff ? wstrb0_ff : s_axi_wstrb[0];
    // every beat is answered, even one that has no effect
    wire do_write = aw_now & w_now & ~bvalid_ff;
    // only byte lane 0 gates an effect; the opcode sits in lane 1, so a
    // narrow store without lane 0 cannot issue half an instruction
    wire wr_ok = do_write & lane0;

    // instruction written to the issue register
    // decoding is pure logic on the write word, so the instruction runs
    // at the very edge that completes the write
    wire issue = wr_ok & (wa == `AALO_REG_INSN);
    wire [13:0] insn = wd[13:0]; // instruction word
    wire [2:0] cls = decode(insn[13:8]); // instruction class
    wire is_lit = (cls == CL_ADDLIT) | (cls == CL_ANDLIT); // literal forms
    wire is_file = (cls == CL_ADDFILE) | (cls == CL_ANDFILE); // file forms
    wire is_and = (cls == CL_ANDLIT) | (cls == CL_ANDFILE); // logic, not add
    wire dest_file = insn[`AALO_DEST_BIT]; // destination select
    wire [6:0] fa = insn[`AALO_FADDR_MSB:0]; // file address field
    // literal forms take the low byte, file forms read the addressed entry
    wire [7:0] opb = is_lit ? insn[`AALO_LIT_MSB:0] : file_ff[fa];

    // shared arithmetic unit; one adder serves both add forms and the
    // and forms reuse its zero detect
    wire [7:0] alu_res; // add or and result
    wire alu_c; // carry out of bit 7
    wire alu_dc; // carry out of bit 3
    wire alu_z; // result is zero
    aalo_alu #(
        .WIDTH(8)
    ) u_alu (
        .opa(acc_ff),
        .opb(opb),
        .do_and(is_and),
        .result(alu_res),
        .carry(alu_c),
        .digit_carry(alu_dc),
        .zero(alu_z)
    );

    // next values of acc and status
    // an issue and a direct acc or status load never meet: both need
    // the one write beat, and its address picks only one of them
    reg [7:0] nxt_acc; // next working register
    reg [2:0] nxt_status; // next flags
    always @* begin
        // hold by default
        nxt_acc = acc_ff;
        nxt_status = status_ff;
        if (issue && cls != CL_NONE) begin
            // and leaves carry and digit carry untouched
            if (!is_and) begin
                nxt_status[`AALO_ST_CARRY] = alu_c;
                nxt_status[`AALO_ST_DIGIT] = alu_dc;
            end
            // zero follows every one of the four forms
            nxt_status[`AALO_ST_ZERO] = alu_z;
            // literal forms always land in acc
            if (is_lit || !dest_file)
                nxt_acc = alu_res;
        end else if (wr_ok && wa == `AALO_REG_ACC) begin
            // direct software load of acc
            nxt_acc = wd[7:0];
        end else if (wr_ok && wa == `AALO_REG_STATUS) begin
            // direct software load of flags
            nxt_status = wd[2:0];
        end
    end

    // datapath registers update in the issuing cycle
    // so the next instruction written already sees the new acc and flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            acc_ff <= `AALO_ACC_RST;
            status_ff <= `AALO_STATUS_RST;
            faddr_ff <= 7'h00;
            count_ff <= 16'h0000;
        end else begin
            acc_ff <= nxt_acc;
            status_ff <= nxt_status;
            // window pointer for file access from software
            if (wr_ok && wa == `AALO_REG_FADDR)
                faddr_ff <= wd[6:0];
            // ignored words do not count; the counter wraps silently
            if (issue && cls != CL_NONE)
                count_ff <= count_ff + 16'h0001;
        end
    end

    // file registers, one generate slice per entry
    // an instruction result and a software store never share a beat,
    // since both need the one write beat with different addresses
    genvar gi;
    generate
        for (gi = 0; gi < FILE_DEPTH; gi = gi + 1) begin : g_file
            always @(posedge aclk) begin
                if (!aresetn) begin
                    file_ff[gi] <= `AALO_FILE_RST;
                end else if (issue && is_file && dest_file && fa == gi) begin
                    // write back to the addressed entry, acc untouched
                    file_ff[gi] <= alu_res;
                end else if (wr_ok && wa == `AALO_REG_FDATA && faddr_ff == gi) begin
                    // software store through the window
                    file_ff[gi] <= wd[7:0];
                end
            end
        end
    endgenerate

    // true if a byte address is mapped
    // an unmapped write is answered with an error and changes nothing
    function mapped;
        input [AW-1:0] a;
        begin
            mapped = (a == `AALO_REG_INSN) | (a == `AALO_REG_ACC) |
                     (a == `AALO_REG_STATUS) | (a == `AALO_REG_FADDR) |
                     (a == `AALO_REG_FDATA) | (a == `AALO_REG_COUNT);
        end
    endfunction

    // write channels: accept address and data in either order
    // each slot closes once its half is taken and reopens only after the
    // answer is taken, so one write at most is ever under way
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            have_aw_ff <= 1'b0;
            have_w_ff <= 1'b0;
            awaddr_ff <= {AW{1'b0}};
            wdata_ff <= 32'h00000000;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `AALO_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                // park the address
                awaddr_ff <= s_axi_awaddr;
                awready_ff <= 1'b0;
                have_aw_ff <= 1'b1;
            end
            if (w_fire) begin
                // park the data together with its lane 0 strobe
                wstrb0_ff <= s_axi_wstrb[0];
                wdata_ff <= s_axi_wdata;
                wready_ff <= 1'b0;
                have_w_ff <= 1'b1;
            end
            if (do_write) begin
                // response one cycle after both halves are in
                bvalid_ff <= 1'b1;
                bresp_ff <= mapped(wa) ? `AALO_RESP_OKAY : `AALO_RESP_SLVERR;
                have_aw_ff <= 1'b0;
                have_w_ff <= 1'b0;
                awready_ff <= 1'b0;
                wready_ff <= 1'b0;
            end
            // answer taken: reopen both slots
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // read channel: one read under way at a time
    // the word is captured at the address edge and held until taken,
    // so a later instruction cannot tear an answer already given
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `AALO_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= `AALO_RESP_OKAY;
            case (s_axi_araddr)
                `AALO_REG_INSN: rdata_ff <= 32'h00000000;
                `AALO_REG_ACC: rdata_ff <= {24'h000000, acc_ff};
                `AALO_REG_STATUS: rdata_ff <= {29'h00000000, status_ff};
                `AALO_REG_FADDR: rdata_ff <= {25'h0000000, faddr_ff};
                `AALO_REG_FDATA: rdata_ff <= {24'h000000, file_ff[faddr_ff]};
                `AALO_REG_COUNT: rdata_ff <= {16'h0000, count_ff};
                default: begin
                    // unmapped place: error code and zero data
                    rdata_ff <= 32'h00000000;
                    rresp_ff <= `AALO_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // outputs straight from flip-flops
    // no logic between the registers and the ports
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule
`default_nettype wire

// ==== verilog/aalo_regs.vh ====
// constants for the add and logic datapath: opcodes, fields, register map
`ifndef AALO_REGS_VH
`define AALO_REGS_VH
// instruction field positions
`define AALO_LIT_MSB 7
`define AALO_FADDR_MSB 6
`define AALO_DEST_BIT 7
// opcode upper six bits, bits 13..8
`define AALO_OP_ADDLIT_MASK 6'h3E
`define AALO_OP_ADDLIT 6'h3E
`define AALO_OP_ANDLIT 6'h39
`define AALO_OP_ADDFILE 6'h07
`define AALO_OP_ANDFILE 6'h05
// status flag bit positions
`define AALO_ST_CARRY 0
`define AALO_ST_DIGIT 1
`define AALO_ST_ZERO 2
// axi register byte offsets
`define AALO_REG_INSN 8'h00
`define AALO_REG_ACC 8'h04
`define AALO_REG_STATUS 8'h08
`define AALO_REG_FADDR 8'h0C
`define AALO_REG_FDATA 8'h10
`define AALO_REG_COUNT 8'h14
// reset values
`define AALO_ACC_RST 8'h00
`define AALO_STATUS_RST 3'h0
`define AALO_FILE_RST 8'h00
// axi responses
`define AALO_RESP_OKAY 2'h0
`define AALO_RESP_SLVERR 2'h2
`endif

// ==== verilog/aalo_alu.v ====
// combinational adder and and-unit with carry, digit carry and zero
`timescale 1ns/10ps
`default_nettype none
module aalo_alu #(
    parameter WIDTH = 8
) (
    // operands and operation select
    input wire [WIDTH-1:0] opa,
    input wire [WIDTH-1:0] opb,
    input wire do_and,
    // result and flags
    output wire [WIDTH-1:0] result,
    output wire carry,
    output wire digit_carry,
    output wire zero
);
    wire [WIDTH:0] sum; // sum with carry out
    wire [4:0] low_sum; // low nibble sum for digit carry
    assign sum = {1'b0, opa} + {1'b0, opb};
    assign low_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
    // and path bypasses the adder
    assign result = do_and ? (opa & opb) : sum[WIDTH-1:0];
    assign carry = sum[WIDTH];
    assign digit_carry = low_sum[4];
    assign zero = (result == {WIDTH{1'b0}});
endmodule
`default_nettype wire

// ==== testbench/aalo_core_chk.sv ====
// handshake timing checker for the add and logic datapath
`timescale 1ns/10ps
`default_nettype none
module aalo_core_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // read side
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    // one clock domain, so one default for all
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // both write channels taken at one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // answer pending, new writes refused
    sequence s_b_open;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence
    property p_wr_answer;
        s_wr_take |=> s_b_open;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_close;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_b_close: assert property (p_b_close) else $error("write answer not closed");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_r_close;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_r_close: assert property (p_r_close) else $error("read answer not closed");
    property p_r_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_block: assert property (p_r_block) else $error("read taken while busy");
endmodule
`default_nettype wire

// ==== testbench/add_and_logic_ops_tb.sv ====
// self-checking bench for the add and logic datapath
`timescale 1ns/10ps
`default_nettype none
`include "aalo_regs.vh"
module add_and_logic_ops_tb;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire awready, wready, bvalid, arready, rvalid;
    int err_total = 0, samples_checked = 0, cyc = 0, i;
    // rows: instruction, then acc, status and file word 5 after it
    logic [37:0] rows [10] = '{{14'h3EA3, 8'hA3, 8'h00, 8'hC2}, {14'h395F, 8'h03, 8'h00, 8'hC2},
        {14'h3F14, 8'h17, 8'h00, 8'hC2}, {14'h0705, 8'hD9, 8'h00, 8'hC2},
        {14'h3E27, 8'h00, 8'h07, 8'hC2}, {14'h3900, 8'h00, 8'h07, 8'hC2},
        {14'h3E17, 8'h17, 8'h00, 8'hC2}, {14'h0585, 8'h17, 8'h00, 8'h02},
        {14'h0785, 8'h17, 8'h00, 8'h19}, {14'h0505, 8'h11, 8'h00, 8'h19}};
    always #5 aclk = ~aclk;
    aalo_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task conclude;
        begin
            $display("compares %0d mismatches %0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            samples_checked++;
            if (g !== e) begin
                err_total++;
                $display("[ERR] t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    // one write; a spare edge first so bready never toggles twice in a step
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            do begin
                @(posedge aclk);
                if (awready) awvalid <= 0;
                if (wready) wvalid <= 0;
            end while (bvalid !== 1'b1);
            bready <= 0;
            chk({30'h0, bresp}, {30'h0, er});
        end
    endtask
    // one read, data taken at the edge that shows rvalid
    task rd(input [7:0] a, input [31:0] e, input [1:0] er);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
            do begin
                @(posedge aclk);
                if (arready) arvalid <= 0;
            end while (rvalid !== 1'b1);
            rready <= 0;
            chk(rdata, e);
            chk({30'h0, rresp}, {30'h0, er});
        end
    endtask
    // hang guard, well above the few hundred cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            conclude;
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rd(`AALO_REG_ACC, 0, `AALO_RESP_OKAY);
        rd(`AALO_REG_STATUS, 0, `AALO_RESP_OKAY);
        rd(`AALO_REG_COUNT, 0, `AALO_RESP_OKAY);
        $display("reset values done");
        wr(`AALO_REG_FADDR, 32'h5, `AALO_RESP_OKAY);
        wr(`AALO_REG_FDATA, 32'hC2, `AALO_RESP_OKAY);
        for (i = 0; i < 10; i++) begin
            wr(`AALO_REG_INSN, {18'h0, rows[i][37:24]}, `AALO_RESP_OKAY);
            rd(`AALO_REG_ACC, {24'h0, rows[i][23:16]}, `AALO_RESP_OKAY);
            rd(`AALO_REG_STATUS, {24'h0, rows[i][15:8]}, `AALO_RESP_OKAY);
            rd(`AALO_REG_FDATA, {24'h0, rows[i][7:0]}, `AALO_RESP_OKAY);
            $display("row %0d done", i);
        end
        // back to back adds, second uses first result; then an ignored word
        wr(`AALO_REG_INSN, 32'h00003E01, `AALO_RESP_OKAY);
        wr(`AALO_REG_INSN, 32'h00003EFF, `AALO_RESP_OKAY);
        wr(`AALO_REG_INSN, 32'h00000000, `AALO_RESP_OKAY);
        rd(`AALO_REG_ACC, 32'h00000011, `AALO_RESP_OKAY);
        rd(`AALO_REG_STATUS, 32'h00000003, `AALO_RESP_OKAY);
        rd(`AALO_REG_COUNT, 32'h0000000C, `AALO_RESP_OKAY);
        $display("back to back done");
        // unmapped place refused both ways
        wr(8'h40, 32'h0, `AALO_RESP_SLVERR);
        rd(8'h40, 32'h0, `AALO_RESP_SLVERR);
        // second reset in mid-run, while a write answer is still pending
        @(posedge aclk);
        awaddr <= `AALO_REG_ACC;
        wdata <= 32'h00000055;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        // readies up and answers down once reset has been seen
        chk({27'h0, awready, wready, arready, bvalid, rvalid}, 32'h0000001C);
        aresetn <= 1;
        rd(`AALO_REG_ACC, 0, `AALO_RESP_OKAY);
        rd(`AALO_REG_STATUS, 0, `AALO_RESP_OKAY);
        rd(`AALO_REG_COUNT, 0, `AALO_RESP_OKAY);
        rd(`AALO_REG_FADDR, 0, `AALO_RESP_OKAY);
        wr(`AALO_REG_FADDR, 32'h5, `AALO_RESP_OKAY);
        rd(`AALO_REG_FDATA, 0, `AALO_RESP_OKAY);
        $display("edge tests done");
        conclude;
    end
endmodule
bind aalo_core aalo_core_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire
